/* File: inc/jsp_pkg.sv */
// shared constants and types for the scan port pin block
package jsp_pkg;
	localparam int IR_WIDTH = 4;
	localparam int DR_WIDTH = 8;
	localparam logic [3:0] IR_RESET = 4'h1;
	localparam logic [3:0] IR_BYPASS = 4'hF;
	localparam logic [3:0] IR_EMU_CTRL = 4'h2;
	localparam logic [3:0] IR_CAPTURE_PAT = 4'h1;
	localparam logic [7:0] EMU_CTRL_RESET = 8'h00;
	localparam int EMU_DIR_A = 0;
	localparam int EMU_DIR_B = 1;
	localparam int EMU_OUT_A = 2;
	localparam int EMU_OUT_B = 3;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [15:0] {
		ST_TLR = 16'h0001,
		ST_RTI = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PA_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PA_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} jsp_tap_e;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst;
	} jsp_pins_s;

	typedef struct packed {
		logic dir_a;
		logic dir_b;
		logic out_a;
		logic out_b;
	} jsp_emu_s;
endpackage

/* File: logic/jsp_scan_port.sv */
// scan port: tap controller, registers and emulator event pins
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - test reset high lets the scan logic control the device
// - test reset low keeps functional mode and ignores scan signals
// - mode select sampled into tap controller on each rising test clock edge
// - data input shifted into selected register on each rising test clock edge
// - selected register shifted onto tri-stated data output on falling edges
// - event pin a is emulator interrupt, direction set through scan
// - event pin b is emulator interrupt, direction set through scan
module jsp_scan_port (
	input wire logic ref_clk, // 25 MHz block clock
	input wire logic resetn, // async reset, active low
	input wire jsp_pkg::jsp_pins_s pins, // test clock, mode, data in, test reset
	input wire logic emulator_event_pin_a_in, // event pin a level
	input wire logic emulator_event_pin_b_in, // event pin b level
	input wire logic event_a_req, // core wants to signal on pin a
	input wire logic event_b_req, // core wants to signal on pin b
	output logic scan_control, // scan logic owns the device
	output logic tdo, // test data output level
	output logic tdo_oe_n, // low while tdo is driven
	output logic emulator_event_pin_a_out, // pin a level driven
	output logic emulator_event_pin_a_oe_n, // low while pin a is driven
	output logic emulator_event_pin_b_out, // pin b level driven
	output logic emulator_event_pin_b_oe_n, // low while pin b is driven
	output logic event_a_seen, // pin a input as seen by core
	output logic event_b_seen // pin b input as seen by core
);
	jsp_pkg::jsp_pins_s pins_s;
	logic [1:0] emu_s;
	logic tck_d;
	logic tck_rise;
	logic tck_fall;
	jsp_pkg::jsp_tap_e state;
	jsp_pkg::jsp_tap_e next_state;
	logic [jsp_pkg::IR_WIDTH-1:0] ir_shift;
	logic [jsp_pkg::IR_WIDTH-1:0] ir;
	logic [jsp_pkg::DR_WIDTH-1:0] dr_shift;
	logic bypass;
	jsp_pkg::jsp_emu_s emu_ctrl;
	logic scan_out;
	logic shifting;
	logic sel_ctrl;
	logic [jsp_pkg::DR_WIDTH-1:0] ctrl_cap;

	jsp_sync #(.WIDTH(4)) u_pin_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.din(pins),
		.dout(pins_s)
	);

	jsp_sync #(.WIDTH(2)) u_emu_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.din({emulator_event_pin_b_in, emulator_event_pin_a_in}),
		.dout(emu_s)
	);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tck_d <= 1'b0;
		end else begin
			tck_d <= pins_s.tck;
		end
	end

	// edges only count while scan owns the port
	assign tck_rise = pins_s.trst & pins_s.tck & ~tck_d;
	assign tck_fall = pins_s.trst & ~pins_s.tck & tck_d;
	assign sel_ctrl = (ir == jsp_pkg::IR_EMU_CTRL);

	always_comb begin
		next_state = state;
		case (state)
			jsp_pkg::ST_TLR: next_state = pins_s.tms ? jsp_pkg::ST_TLR : jsp_pkg::ST_RTI;
			jsp_pkg::ST_RTI: next_state = pins_s.tms ? jsp_pkg::ST_SEL_DR : jsp_pkg::ST_RTI;
			jsp_pkg::ST_SEL_DR: next_state = pins_s.tms ? jsp_pkg::ST_SEL_IR : jsp_pkg::ST_CAP_DR;
			jsp_pkg::ST_CAP_DR: next_state = pins_s.tms ? jsp_pkg::ST_EX1_DR : jsp_pkg::ST_SH_DR;
			jsp_pkg::ST_SH_DR: next_state = pins_s.tms ? jsp_pkg::ST_EX1_DR : jsp_pkg::ST_SH_DR;
			jsp_pkg::ST_EX1_DR: next_state = pins_s.tms ? jsp_pkg::ST_UPD_DR : jsp_pkg::ST_PA_DR;
			jsp_pkg::ST_PA_DR: next_state = pins_s.tms ? jsp_pkg::ST_EX2_DR : jsp_pkg::ST_PA_DR;
			jsp_pkg::ST_EX2_DR: next_state = pins_s.tms ? jsp_pkg::ST_UPD_DR : jsp_pkg::ST_SH_DR;
			jsp_pkg::ST_UPD_DR: next_state = pins_s.tms ? jsp_pkg::ST_SEL_DR : jsp_pkg::ST_RTI;
			jsp_pkg::ST_SEL_IR: next_state = pins_s.tms ? jsp_pkg::ST_TLR : jsp_pkg::ST_CAP_IR;
			jsp_pkg::ST_CAP_IR: next_state = pins_s.tms ? jsp_pkg::ST_EX1_IR : jsp_pkg::ST_SH_IR;
			jsp_pkg::ST_SH_IR: next_state = pins_s.tms ? jsp_pkg::ST_EX1_IR : jsp_pkg::ST_SH_IR;
			jsp_pkg::ST_EX1_IR: next_state = pins_s.tms ? jsp_pkg::ST_UPD_IR : jsp_pkg::ST_PA_IR;
			jsp_pkg::ST_PA_IR: next_state = pins_s.tms ? jsp_pkg::ST_EX2_IR : jsp_pkg::ST_PA_IR;
			jsp_pkg::ST_EX2_IR: next_state = pins_s.tms ? jsp_pkg::ST_UPD_IR : jsp_pkg::ST_SH_IR;
			jsp_pkg::ST_UPD_IR: next_state = pins_s.tms ? jsp_pkg::ST_SEL_DR : jsp_pkg::ST_RTI;
			default: next_state = jsp_pkg::ST_TLR;
		endcase
	end

	// tap state: mode select taken on rising test clock
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= jsp_pkg::ST_TLR;
		end else if (!pins_s.trst) begin
			state <= jsp_pkg::ST_TLR;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end

	// instruction register path
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ir_shift <= jsp_pkg::IR_RESET;
			ir <= jsp_pkg::IR_RESET;
		end else if (!pins_s.trst || state == jsp_pkg::ST_TLR) begin
			ir_shift <= jsp_pkg::IR_RESET;
			ir <= jsp_pkg::IR_RESET;
		end else if (tck_rise) begin
			case (state)
				jsp_pkg::ST_CAP_IR: ir_shift <= jsp_pkg::IR_CAPTURE_PAT;
				jsp_pkg::ST_SH_IR: ir_shift <= {pins_s.tdi, ir_shift[jsp_pkg::IR_WIDTH-1:1]};
				jsp_pkg::ST_UPD_IR: ir <= ir_shift;
				default: ir <= ir;
			endcase
		end
	end

	// capture word uses the same bit positions as the update, pin levels above them
	always_comb begin
		ctrl_cap = '0;
		ctrl_cap[jsp_pkg::EMU_DIR_A] = emu_ctrl.dir_a;
		ctrl_cap[jsp_pkg::EMU_DIR_B] = emu_ctrl.dir_b;
		ctrl_cap[jsp_pkg::EMU_OUT_A] = emu_ctrl.out_a;
		ctrl_cap[jsp_pkg::EMU_OUT_B] = emu_ctrl.out_b;
		ctrl_cap[5:4] = emu_s;
	end

	// data register path: emulator pin control register or bypass
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dr_shift <= jsp_pkg::EMU_CTRL_RESET;
			bypass <= 1'b0;
		end else if (tck_rise) begin
			case (state)
				jsp_pkg::ST_CAP_DR: begin
					dr_shift <= ctrl_cap;
					bypass <= 1'b0;
				end
				jsp_pkg::ST_SH_DR: begin
					dr_shift <= {pins_s.tdi, dr_shift[jsp_pkg::DR_WIDTH-1:1]};
					bypass <= pins_s.tdi;
				end
				default: bypass <= bypass;
			endcase
		end
	end

	// direction and drive of the event pins set through scan
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			emu_ctrl <= '0;
		end else if (!pins_s.trst) begin
			emu_ctrl <= '0;
		end else if (tck_rise && state == jsp_pkg::ST_UPD_DR && sel_ctrl) begin
			emu_ctrl.dir_a <= dr_shift[jsp_pkg::EMU_DIR_A];
			emu_ctrl.dir_b <= dr_shift[jsp_pkg::EMU_DIR_B];
			emu_ctrl.out_a <= dr_shift[jsp_pkg::EMU_OUT_A];
			emu_ctrl.out_b <= dr_shift[jsp_pkg::EMU_OUT_B];
		end
	end

	always_comb begin
		shifting = (state == jsp_pkg::ST_SH_DR) || (state == jsp_pkg::ST_SH_IR);
		if (state == jsp_pkg::ST_SH_IR) begin
			scan_out = ir_shift[0];
		end else if (sel_ctrl) begin
			scan_out = dr_shift[0];
		end else begin
			scan_out = bypass;
		end
	end

	// data output changes on falling test clock, released outside shifts
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (!pins_s.trst) begin
			tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			tdo <= scan_out;
			tdo_oe_n <= ~shifting;
		end
	end

	// scan ownership follows the synchronised test reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			scan_control <= 1'b0;
		end else begin
			scan_control <= pins_s.trst;
		end
	end

	// event pin a: driven only with test reset high and output role chosen
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			emulator_event_pin_a_out <= 1'b0;
			emulator_event_pin_a_oe_n <= 1'b1;
			event_a_seen <= 1'b0;
		end else begin
			emulator_event_pin_a_out <= emu_ctrl.out_a | event_a_req;
			emulator_event_pin_a_oe_n <= ~(pins_s.trst & emu_ctrl.dir_a);
			event_a_seen <= pins_s.trst & ~emu_ctrl.dir_a & emu_s[0];
		end
	end

	// event pin b: same roles as pin a, own control bits
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			emulator_event_pin_b_out <= 1'b0;
			emulator_event_pin_b_oe_n <= 1'b1;
			event_b_seen <= 1'b0;
		end else begin
			emulator_event_pin_b_out <= emu_ctrl.out_b | event_b_req;
			emulator_event_pin_b_oe_n <= ~(pins_s.trst & emu_ctrl.dir_b);
			event_b_seen <= pins_s.trst & ~emu_ctrl.dir_b & emu_s[1];
		end
	end
endmodule
`default_nettype wire

/* File: logic/jsp_sync.sv */
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module jsp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk, // block clock
	input wire logic resetn, // async reset, active low
	input wire logic [WIDTH-1:0] din, // asynchronous inputs
	output logic [WIDTH-1:0] dout // synchronised inputs
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule
`default_nettype wire

/* File: verification/jsp_debugger.sv */
// debugger pod model driving the scan port pins
`timescale 1ns/1ps
`default_nettype none
module jsp_debugger (
	input wire logic clk, // paces the pod
	input wire logic tdo, // scan data from the device
	input wire logic tdo_oe_n, // low while tdo is driven
	output var jsp_pkg::jsp_pins_s pins // pod outputs
);
	initial pins = 4'hE;
	// test reset level, changed just after a clock edge
	task automatic set_trst(input logic v);
		pins.trst <= v;
	endtask
	// one test clock period; tdo is read late in the high phase, x when undriven
	task automatic cyc(input logic ms, input logic di, output logic so);
		pins.tms <= ms;
		pins.tdi <= di;
		pins.tck <= 1'b0;
		repeat (4) @(posedge clk);
		pins.tck <= 1'b1;
		repeat (4) @(posedge clk);
		so = tdo_oe_n ? 1'bx : tdo;
	endtask
	// from idle through capture, n shifts lsb first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [7:0] din, output logic [7:0] dout);
		logic b;
		dout = 8'h00;
		cyc(1'b1, 1'b1, b);
		if (ir) begin
			cyc(1'b1, 1'b1, b);
		end
		cyc(1'b0, 1'b1, b);
		cyc(1'b0, 1'b1, b);
		for (int i = 0; i < n; i++) begin
			cyc(i == n - 1, din[i], b);
			dout[i] = b;
		end
		cyc(1'b1, 1'b1, b);
		cyc(1'b0, 1'b1, b);
	endtask
endmodule
`default_nettype wire

/* File: verification/jsp_scan_port_bench.sv */
// self-checking bench for the scan port pins
`timescale 1ns/1ps
`default_nettype none
module jsp_scan_port_bench;
	logic ref_clk, tdo, tdo_oe_n, scan_control, pa, pb, a_out, a_oe_n, b_out, b_oe_n, seen_a, seen_b, junk;
	logic resetn = 1'b0, req_a = 1'b0, req_b = 1'b0, ea = 1'b1, eb = 1'b1;
	logic [7:0] got, exp, ctl, rnd;
	int n_mismatch, n_checks;
	jsp_pkg::jsp_pins_s pins;
	assign pa = a_oe_n ? ea : a_out;
	assign pb = b_oe_n ? eb : b_out;
	jsp_debugger jsp_debugger_inst (.clk(ref_clk), .tdo, .tdo_oe_n, .pins);
	jsp_scan_port jsp_scan_port_inst (.ref_clk, .resetn, .pins, .emulator_event_pin_a_in(pa),
		.emulator_event_pin_b_in(pb), .event_a_req(req_a), .event_b_req(req_b), .scan_control, .tdo, .tdo_oe_n,
		.emulator_event_pin_a_out(a_out), .emulator_event_pin_a_oe_n(a_oe_n), .emulator_event_pin_b_out(b_out),
		.emulator_event_pin_b_oe_n(b_oe_n), .event_a_seen(seen_a), .event_b_seen(seen_b));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// capture of the emulator control scan: expected pin levels above the control bits
	function automatic logic [7:0] cap(input logic [7:0] c);
		return {2'b00, (c[1] ? (c[3] | req_b) : eb), (c[0] ? (c[2] | req_a) : ea), c[3:0]};
	endfunction
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		results();
	end
	initial begin
		void'($urandom(32'hC965));
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			jsp_debugger_inst.cyc(1'($urandom), 1'($urandom), junk);
		end
		chk({4'h0, scan_control, tdo_oe_n, a_oe_n, b_oe_n}, 8'h07);
		jsp_debugger_inst.set_trst(1'b1);
		repeat (6) @(posedge ref_clk);
		chk({7'h00, scan_control}, 8'h01);
		for (int i = 0; i < 6; i++) begin
			jsp_debugger_inst.cyc(i < 5, 1'b1, junk);
		end
		jsp_debugger_inst.scan(1'b1, 4, {4'h0, jsp_pkg::IR_EMU_CTRL}, got);
		chk(got, {4'h0, jsp_pkg::IR_CAPTURE_PAT});
		ctl = jsp_pkg::EMU_CTRL_RESET;
		for (int k = 0; k < 6; k++) begin
			req_a <= 1'($urandom);
			req_b <= 1'($urandom);
			ea <= 1'($urandom);
			eb <= 1'($urandom);
			repeat (6) @(posedge ref_clk);
			exp = cap(ctl);
			ctl = k == 0 ? 8'h0F : {4'h0, 4'($urandom)};
			jsp_debugger_inst.scan(1'b0, 8, ctl, got);
			chk(got, exp);
			repeat (8) @(posedge ref_clk);
			chk({6'h00, ctl[0] ? a_out : seen_a, a_oe_n}, {6'h00, ctl[0] ? ctl[2] | req_a : ea, ~ctl[0]});
			chk({6'h00, ctl[1] ? b_out : seen_b, b_oe_n}, {6'h00, ctl[1] ? ctl[3] | req_b : eb, ~ctl[1]});
		end
		jsp_debugger_inst.scan(1'b1, 4, {4'h0, jsp_pkg::IR_BYPASS}, got);
		chk(got, {4'h0, jsp_pkg::IR_CAPTURE_PAT});
		rnd = 8'($urandom);
		jsp_debugger_inst.scan(1'b0, 8, rnd, got);
		chk(got, {rnd[6:0], 1'b0});
		jsp_debugger_inst.set_trst(1'b0);
		repeat (6) @(posedge ref_clk);
		chk({4'h0, scan_control, tdo_oe_n, a_oe_n, b_oe_n}, 8'h07);
		results();
	end
endmodule
`default_nettype wire

/* File: verification/jsp_scan_port_properties.sv */
// checker for the scan port pin behaviour
`timescale 1ns/1ps
`default_nettype none
module jsp_scan_port_chk (
	input wire logic ref_clk, // block clock
	input wire logic resetn, // async reset, active low
	input wire logic scan_control, // scan owns the device
	input wire logic tdo, // test data output
	input wire logic tdo_oe_n, // low while tdo is driven
	input wire logic event_a_seen, // pin a as seen by core
	input wire logic event_b_seen, // pin b as seen by core
	input wire logic emulator_event_pin_a_oe_n, // low while pin a is driven
	input wire logic emulator_event_pin_b_oe_n, // low while pin b is driven
	input wire jsp_pkg::jsp_pins_s pins // pod pins
);
	logic [6:0] th;
	logic fell_near;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// recent test clock samples, to find a falling edge a few cycles back
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			th <= 7'h7F;
		end else begin
			th <= {th[5:0], pins.tck};
		end
	end
	assign fell_near = |(th[6:2] & ~th[5:1]);
	a_scan_takes_over: assert property (pins.trst [*4] |=> scan_control)
		else $error("scan control missing");
	a_functional_mode: assert property (!pins.trst [*4] |=> !scan_control)
		else $error("scan control stuck");
	a_tap_held_reset: assert property (!pins.trst [*4] |=> tdo_oe_n && !event_a_seen && !event_b_seen)
		else $error("scan logic not held");
	a_shift_entry: assert property ($fell(tdo_oe_n) |-> scan_control && fell_near)
		else $error("shift entered wrongly");
	a_tdo_on_fall: assert property ($changed(tdo) && !tdo_oe_n |-> fell_near)
		else $error("tdo moved off fall");
	a_oe_on_fall: assert property ($changed(tdo_oe_n) && scan_control |-> fell_near)
		else $error("tdo enable moved off fall");
	a_pin_a_scan: assert property ($fell(emulator_event_pin_a_oe_n) |-> scan_control && pins.trst)
		else $error("pin a driven outside scan");
	a_pin_b_scan: assert property ($fell(emulator_event_pin_b_oe_n) |-> scan_control && pins.trst)
		else $error("pin b driven outside scan");
	c_shift: cover property ($fell(tdo_oe_n));
	c_pin_a: cover property ($fell(emulator_event_pin_a_oe_n));
	c_seen_b: cover property (event_b_seen);
endmodule
bind jsp_scan_port jsp_scan_port_chk jsp_scan_port_chk_inst (.ref_clk, .resetn, .scan_control, .tdo, .tdo_oe_n,
	.event_a_seen, .event_b_seen, .emulator_event_pin_a_oe_n, .emulator_event_pin_b_oe_n, .pins);
`default_nettype wire
